// ### verilog/imupm_pkg.sv
/*
 * Shared constants and types for the motion sensor power-mode and register-bank block.
 * Assumes a 50 MHz system clock and a host serial port clocked from outside.
 */
package imupm_pkg;

    // ==========================================================
    // Register map
    localparam logic [6:0] BANK_SEL_ADDR    = 7'h01;
    localparam int         PROC_ACCESS_BIT  = 7;
    localparam int         HUB_ACCESS_BIT   = 6;
    localparam logic [7:0] BANK_SEL_RESET   = 8'h00;
    localparam logic [6:0] ACCEL_CTRL_ADDR  = 7'h10;
    localparam logic [6:0] GYRO_CTRL_ADDR   = 7'h11;
    localparam logic [6:0] FOURTH_CTRL_ADDR = 7'h13;
    localparam logic [6:0] SIXTH_CTRL_ADDR  = 7'h15;
    localparam logic [6:0] GYRO_EXTRA_ADDR  = 7'h16;
    localparam logic [6:0] OUT_FIRST_ADDR   = 7'h22;
    localparam logic [6:0] OUT_LAST_ADDR    = 7'h2D;
    localparam logic [5:0] HUB_PULLUP_ADDR  = 6'h14;
    localparam int         HUB_PULLUP_BIT   = 3;
    localparam int         HUB_MASTER_BIT   = 2;
    localparam int         HUB_COUNT_LSB    = 0;
    localparam int         RATE_LSB         = 4;
    localparam int         SLEEP_BIT        = 6;
    localparam int         ACCEL_PERF_BIT   = 4;
    localparam int         GYRO_PERF_BIT    = 7;
    localparam logic [7:0] MEM_RESET        = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_HZ       = 50_000_000;
    localparam int BOOT_TIME_MS = 10;
    localparam int BOOT_CYC     = BOOT_TIME_MS * (CLK_HZ / 1000);
    localparam int RATE_CODE_MAX = 10;
    localparam int TB_UNIT_CYC  = 16;
    localparam int LP_ON_CYC    = 4;
    localparam logic [4:0] SPI_DATA_BIT  = 5'd16;
    localparam logic [4:0] SPI_LAST_BIT  = 5'd24;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        PM_DOWN  = 4'b0001,
        PM_LOW   = 4'b0010,
        PM_HIGH  = 4'b0100,
        PM_SLEEP = 4'b1000
    } imupm_mode_t;

    typedef enum logic [1:0] {
        CM_PLAIN = 2'b01,
        CM_HUB   = 2'b10
    } imupm_conn_t;

    typedef struct packed {
        imupm_mode_t mode;
        logic        drive_on;
        logic        chain_on;
    } imupm_pwr_t;

    typedef struct packed {
        logic       rd;
        logic [6:0] addr;
    } imupm_cmd_t;

endpackage

// ### verilog/imupm_ctrl.sv
/*
 * Power-mode control, sample timebase and banked register file behind a 4-wire SPI slave port.
 * Assumes spi_sclk idles high (mode 3), spi_cs_n low frames a transfer, and a front end
 * that presents fresh samples on accel_sample and gyro_sample whenever asked.
 */
`timescale 1ns/1ps

module imupm_ctrl
    import imupm_pkg::*;
#(
    parameter int BOOT_CYCLES = BOOT_CYC,
    parameter int TB_UNIT     = TB_UNIT_CYC,
    parameter int LP_ON       = LP_ON_CYC
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso_o,
    output logic             spi_miso_oe,
    input  wire logic [6:0]  core_addr,
    input  wire logic        core_wr,
    input  wire logic [7:0]  core_wdata,
    output logic      [7:0]  core_rdata,
    input  wire logic [47:0] accel_sample,
    input  wire logic [47:0] gyro_sample,
    output imupm_pwr_t       accel_pwr,
    output imupm_pwr_t       gyro_pwr,
    output logic             accel_drdy,
    output logic             gyro_drdy,
    output logic             trim_load,
    output imupm_conn_t      conn_mode,
    output logic             hub_pullup_en,
    output logic      [2:0]  hub_sensor_count
);

    // ==========================================================
    // Link side, clocked by the host serial clock
    logic [4:0]  bit_cnt_reg;
    logic [6:0]  shift_reg;
    imupm_cmd_t  cmd_reg;
    logic [7:0]  wdata_reg;
    logic        wr_tgl_reg;
    logic        rd_tgl_reg;
    logic        ack_s1_reg;
    logic        ack_s2_reg;
    logic        ack_seen_reg;
    logic [7:0]  rd_byte_reg;
    logic        miso_reg;
    logic        rd_ack_tgl_reg;
    logic [7:0]  rdata_reg;

    // The frame select clears the bit counter, so counting and command capture ignore sclk edges outside a frame.
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_reg <= 5'd0;
            shift_reg   <= 7'h00;
        end else begin
            shift_reg <= {shift_reg[5:0], spi_mosi};
            if (bit_cnt_reg != SPI_LAST_BIT) begin
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
        end
    end

    always_ff @(posedge spi_sclk or posedge reset) begin
        if (reset) begin
            cmd_reg    <= '0;
            wdata_reg  <= 8'h00;
            wr_tgl_reg <= 1'b0;
            rd_tgl_reg <= 1'b0;
        end else if (!spi_cs_n) begin
            if (bit_cnt_reg == 5'd7) begin
                cmd_reg <= {shift_reg, spi_mosi};
                if (shift_reg[6]) begin
                    rd_tgl_reg <= ~rd_tgl_reg;
                end
            end
            if (bit_cnt_reg == 5'd15 && !cmd_reg.rd) begin
                wdata_reg  <= {shift_reg, spi_mosi};
                wr_tgl_reg <= ~wr_tgl_reg;
            end
        end
    end

    // Read data crosses by handshake: rdata_reg is stable once the acknowledge toggle is seen.
    always_ff @(posedge spi_sclk or posedge reset) begin
        if (reset) begin
            ack_s1_reg   <= 1'b0;
            ack_s2_reg   <= 1'b0;
            ack_seen_reg <= 1'b0;
            rd_byte_reg  <= 8'h00;
        end else begin
            ack_s1_reg <= rd_ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
            if (ack_s2_reg != ack_seen_reg) begin
                ack_seen_reg <= ack_s2_reg;
                rd_byte_reg  <= rdata_reg;
            end
        end
    end

    always_ff @(negedge spi_sclk or posedge reset) begin
        if (reset) begin
            miso_reg <= 1'b0;
        end else begin
            miso_reg <= rd_byte_reg[~bit_cnt_reg[2:0]];
        end
    end

    assign spi_miso_o  = miso_reg;
    assign spi_miso_oe = !spi_cs_n && cmd_reg.rd && (bit_cnt_reg >= SPI_DATA_BIT);

    // ==========================================================
    // Event crossing into the system clock
    logic [2:0] wr_sync_reg;
    logic [2:0] rd_sync_reg;
    logic       wr_pulse;
    logic       rd_pulse;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_sync_reg <= 3'b000;
            rd_sync_reg <= 3'b000;
        end else begin
            wr_sync_reg <= {wr_sync_reg[1:0], wr_tgl_reg};
            rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
        end
    end

    assign wr_pulse = wr_sync_reg[1] ^ wr_sync_reg[2];
    assign rd_pulse = rd_sync_reg[1] ^ rd_sync_reg[2];

    // ==========================================================
    // Boot
    logic [31:0] boot_cnt_reg;
    logic        booting_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            boot_cnt_reg <= 32'd0;
            booting_reg  <= 1'b1;
        end else if (booting_reg) begin
            boot_cnt_reg <= boot_cnt_reg + 32'd1;
            if (boot_cnt_reg == 32'(BOOT_CYCLES - 1)) begin
                booting_reg <= 1'b0;
            end
        end
    end

    assign trim_load = booting_reg;

    // ==========================================================
    // Register banks
    logic [7:0]  bank_sel_reg;
    logic [7:0]  main_mem [0:127];
    logic [7:0]  hub_mem  [0:63];
    logic [7:0]  proc_mem [0:127];
    logic [47:0] accel_out_reg;
    logic [47:0] gyro_out_reg;
    logic [95:0] out_bytes;
    logic        host_ok;
    logic        is_out;
    logic [6:0]  out_idx;
    logic [7:0]  host_rd_next;

    assign host_ok   = !booting_reg;
    assign out_bytes = {accel_out_reg, gyro_out_reg};
    assign is_out    = cmd_reg.addr >= OUT_FIRST_ADDR && cmd_reg.addr <= OUT_LAST_ADDR;
    assign out_idx   = cmd_reg.addr - OUT_FIRST_ADDR;

    always_comb begin
        host_rd_next = 8'h00;
        if (cmd_reg.addr == BANK_SEL_ADDR) begin
            host_rd_next = bank_sel_reg;
        end else if (bank_sel_reg[PROC_ACCESS_BIT]) begin
            host_rd_next = proc_mem[cmd_reg.addr];
        end else if (bank_sel_reg[HUB_ACCESS_BIT]) begin
            host_rd_next = hub_mem[cmd_reg.addr[5:0]];
        end else if (is_out) begin
            host_rd_next = out_bytes[out_idx[3:0] * 8 +: 8];
        end else begin
            host_rd_next = main_mem[cmd_reg.addr];
        end
    end

    // Host reads stay served in power-down; only boot holds them off, answering zero.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_reg      <= 8'h00;
            rd_ack_tgl_reg <= 1'b0;
        end else if (rd_pulse) begin
            rdata_reg      <= host_ok ? host_rd_next : 8'h00;
            rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bank_sel_reg <= BANK_SEL_RESET;
        end else if (wr_pulse && host_ok && cmd_reg.addr == BANK_SEL_ADDR) begin
            bank_sel_reg <= wdata_reg;
        end
    end

    // Mode changes never touch these arrays, so configuration survives power-down.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 128; i++) begin
                main_mem[i] <= MEM_RESET;
            end
        end else if (wr_pulse && host_ok && cmd_reg.addr != BANK_SEL_ADDR && !is_out
                     && bank_sel_reg[PROC_ACCESS_BIT] == 1'b0 && bank_sel_reg[HUB_ACCESS_BIT] == 1'b0) begin
            main_mem[cmd_reg.addr] <= wdata_reg;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 64; i++) begin
                hub_mem[i] <= MEM_RESET;
            end
        end else if (wr_pulse && host_ok && cmd_reg.addr != BANK_SEL_ADDR
                     && !bank_sel_reg[PROC_ACCESS_BIT] && bank_sel_reg[HUB_ACCESS_BIT]) begin
            hub_mem[cmd_reg.addr[5:0]] <= wdata_reg;
        end
    end

    // The core writes last, so it wins a same-cycle clash on one address.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 128; i++) begin
                proc_mem[i] <= MEM_RESET;
            end
        end else begin
            if (wr_pulse && host_ok && cmd_reg.addr != BANK_SEL_ADDR && bank_sel_reg[PROC_ACCESS_BIT]) begin
                proc_mem[cmd_reg.addr] <= wdata_reg;
            end
            if (core_wr) begin
                proc_mem[core_addr] <= core_wdata;
            end
        end
    end

    assign core_rdata = proc_mem[core_addr];

    // ==========================================================
    // Connection mode
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            conn_mode        <= CM_PLAIN;
            hub_pullup_en    <= 1'b0;
            hub_sensor_count <= 3'd0;
        end else begin
            conn_mode        <= hub_mem[HUB_PULLUP_ADDR][HUB_MASTER_BIT] ? CM_HUB : CM_PLAIN;
            hub_pullup_en    <= hub_mem[HUB_PULLUP_ADDR][HUB_PULLUP_BIT];
            hub_sensor_count <= hub_mem[HUB_PULLUP_ADDR][HUB_MASTER_BIT]
                                ? {1'b0, hub_mem[HUB_PULLUP_ADDR][HUB_COUNT_LSB +: 2]} + 3'd1 : 3'd0;
        end
    end

    // ==========================================================
    // Mode decode and shared timebase
    logic [3:0]  accel_rate;
    logic [3:0]  gyro_rate;
    imupm_mode_t accel_mode_next;
    imupm_mode_t gyro_mode_next;
    logic [23:0] tb_cnt_reg;
    logic [23:0] accel_mask;
    logic [23:0] gyro_mask;
    logic        accel_tick;
    logic        gyro_tick;
    logic        accel_window;
    logic        gyro_window;

    assign accel_rate = main_mem[ACCEL_CTRL_ADDR][RATE_LSB +: 4];
    assign gyro_rate  = main_mem[GYRO_CTRL_ADDR][RATE_LSB +: 4];

    function automatic logic [23:0] rate_mask(input logic [3:0] code);
        logic [3:0] c;
        c = (code > 4'(RATE_CODE_MAX)) ? 4'(RATE_CODE_MAX) : code;
        return 24'((TB_UNIT << (RATE_CODE_MAX - int'(c))) - 1);
    endfunction

    function automatic imupm_mode_t pick_mode(input logic [3:0] code, input logic low_pwr, input logic slp);
        if (code == 4'h0) begin
            return PM_DOWN;
        end else if (slp) begin
            return PM_SLEEP;
        end else if (low_pwr) begin
            return PM_LOW;
        end else begin
            return PM_HIGH;
        end
    endfunction

    always_comb begin
        accel_mode_next = pick_mode(accel_rate, main_mem[SIXTH_CTRL_ADDR][ACCEL_PERF_BIT], 1'b0);
        gyro_mode_next  = pick_mode(gyro_rate, main_mem[GYRO_EXTRA_ADDR][GYRO_PERF_BIT],
                                    main_mem[FOURTH_CTRL_ADDR][SLEEP_BIT]);
        if (booting_reg) begin
            accel_mode_next = PM_DOWN;
            gyro_mode_next  = PM_DOWN;
        end
    end

    // One counter serves both sensors; power-of-two periods make every rate pair an integer ratio.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tb_cnt_reg <= 24'd0;
        end else begin
            tb_cnt_reg <= tb_cnt_reg + 24'd1;
        end
    end

    assign accel_mask   = rate_mask(accel_rate);
    assign gyro_mask    = rate_mask(gyro_rate);
    assign accel_tick   = (tb_cnt_reg & accel_mask) == 24'd0;
    assign gyro_tick    = (tb_cnt_reg & gyro_mask) == 24'd0;
    assign accel_window = accel_tick || (tb_cnt_reg & accel_mask) > accel_mask - 24'(LP_ON);
    assign gyro_window  = gyro_tick || (tb_cnt_reg & gyro_mask) > gyro_mask - 24'(LP_ON);

    // ==========================================================
    // Power outputs, sampling and data-ready
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            accel_pwr <= '{mode: PM_DOWN, drive_on: 1'b0, chain_on: 1'b0};
            gyro_pwr  <= '{mode: PM_DOWN, drive_on: 1'b0, chain_on: 1'b0};
        end else begin
            accel_pwr.mode     <= accel_mode_next;
            accel_pwr.drive_on <= accel_mode_next == PM_HIGH || accel_mode_next == PM_LOW;
            accel_pwr.chain_on <= accel_mode_next == PM_HIGH
                                  || (accel_mode_next == PM_LOW && accel_window);
            gyro_pwr.mode      <= gyro_mode_next;
            gyro_pwr.drive_on  <= gyro_mode_next != PM_DOWN;
            gyro_pwr.chain_on  <= gyro_mode_next == PM_HIGH
                                  || (gyro_mode_next == PM_LOW && gyro_window);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            accel_out_reg <= 48'h0;
            accel_drdy    <= 1'b0;
        end else begin
            accel_drdy <= 1'b0;
            if (accel_tick && (accel_mode_next == PM_HIGH || accel_mode_next == PM_LOW)) begin
                accel_out_reg <= accel_sample;
                accel_drdy    <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gyro_out_reg <= 48'h0;
            gyro_drdy    <= 1'b0;
        end else begin
            gyro_drdy <= 1'b0;
            if (gyro_tick && (gyro_mode_next == PM_HIGH || gyro_mode_next == PM_LOW)) begin
                gyro_out_reg <= gyro_sample;
                gyro_drdy    <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence host_wr_hub_s;
        wr_pulse && host_ok && cmd_reg.addr != BANK_SEL_ADDR
            && !bank_sel_reg[PROC_ACCESS_BIT] && bank_sel_reg[HUB_ACCESS_BIT];
    endsequence

    sequence host_wr_main_s;
        wr_pulse && host_ok && cmd_reg.addr != BANK_SEL_ADDR && !is_out && bank_sel_reg[7:6] == 2'b00;
    endsequence

    chk_boot_release: assert property (@(posedge mclk) disable iff (reset)
        booting_reg && boot_cnt_reg == 32'(BOOT_CYCLES - 1) |=> !booting_reg && !trim_load)
        else $error("boot did not end on time");

    chk_boot_down: assert property (@(posedge mclk) disable iff (reset)
        booting_reg |=> accel_pwr.mode == PM_DOWN && gyro_pwr.mode == PM_DOWN)
        else $error("sensor active during boot");

    chk_hub_write: assert property (@(posedge mclk) disable iff (reset)
        host_wr_hub_s |=> hub_mem[$past(cmd_reg.addr[5:0])] == $past(wdata_reg))
        else $error("hub write lost");

    chk_main_write: assert property (@(posedge mclk) disable iff (reset)
        host_wr_main_s |=> main_mem[$past(cmd_reg.addr)] == $past(wdata_reg))
        else $error("main write lost");

    chk_core_write: assert property (@(posedge mclk) disable iff (reset)
        core_wr ##1 !core_wr |-> proc_mem[$past(core_addr)] == $past(core_wdata))
        else $error("core write lost");

    chk_proc_hidden: assert property (@(posedge mclk) disable iff (reset)
        rd_pulse && host_ok && !bank_sel_reg[PROC_ACCESS_BIT] && !bank_sel_reg[HUB_ACCESS_BIT]
            && !is_out && cmd_reg.addr != BANK_SEL_ADDR |=> rdata_reg == main_mem[$past(cmd_reg.addr)])
        else $error("read escaped main bank");

    chk_down_freeze: assert property (@(posedge mclk) disable iff (reset)
        accel_pwr.mode == PM_DOWN && accel_mode_next == PM_DOWN |=> $stable(accel_out_reg) && !accel_drdy)
        else $error("output moved in power-down");

    chk_high_on: assert property (@(posedge mclk) disable iff (reset)
        accel_mode_next == PM_HIGH |=> accel_pwr.chain_on && accel_pwr.drive_on)
        else $error("high-performance chain off");

    chk_low_cycle: assert property (@(posedge mclk) disable iff (reset)
        gyro_mode_next == PM_LOW && !gyro_window |=> gyro_pwr.drive_on && !gyro_pwr.chain_on)
        else $error("low-power duty cycle wrong");

    chk_sleep_entry: assert property (@(posedge mclk) disable iff (reset)
        !booting_reg && gyro_rate != 4'h0 && main_mem[FOURTH_CTRL_ADDR][SLEEP_BIT]
            |=> gyro_pwr.mode == PM_SLEEP && gyro_pwr.drive_on && !gyro_pwr.chain_on && !gyro_drdy)
        else $error("gyro sleep wrong");

    chk_sleep_ignore: assert property (@(posedge mclk) disable iff (reset)
        gyro_rate == 4'h0 |=> gyro_pwr.mode == PM_DOWN && !gyro_pwr.drive_on)
        else $error("sleep bit not ignored");

    chk_rate_sync: assert property (@(posedge mclk) disable iff (reset)
        gyro_tick && accel_rate >= gyro_rate |-> accel_tick)
        else $error("accel tick not aligned");

endmodule

// ### bench/imupm_host_model.sv
/* Host-side SPI master model for the power-mode block.
   Assumes mode 3 framing, one dummy byte before read data, and no other master on the port. */
`timescale 1ns/1ps
module imupm_host_model (
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso_o
);
    // ==========================================================
    // Frame engine
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end

    // The clock stands still between frames, so the link never sees stray edges.
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd, 8'h00};
        rd = 8'h00;
        spi_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            if (!cmd[7] && i < 8) break;
            // A read pauses after the command byte so the fetch and its acknowledge settle before data.
            if (cmd[7] && i == 15) #200;
            #7.5 spi_sclk = 1'b0;
            spi_mosi = sh[i];
            #7.5 spi_sclk = 1'b1;
            if (i < 8) rd[i] = spi_miso_o;
        end
        #7.5 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #100;
    endtask
endmodule

// ### bench/imupm_ctrl_tb.sv
/* Self-checking testbench for imupm_ctrl.
   Assumes the partner model drives the host port and a boot count shortened to 50 cycles. */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module imupm_ctrl_tb
    import imupm_pkg::*;
;
    logic        mclk, reset, sclk, cs_n, mosi, miso_o, miso_oe, core_wr, trim_load, accel_drdy, gyro_drdy, hub_pullup_en;
    logic [6:0]  core_addr;
    logic [7:0]  core_wdata, core_rdata, rd;
    logic [47:0] accel_sample, gyro_sample;
    logic [2:0]  hub_sensor_count;
    imupm_pwr_t  accel_pwr, gyro_pwr;
    imupm_conn_t conn_mode;
    int          fail_count = 0;
    int          checked    = 0;

    // ==========================================================
    // Clock, reset and instances
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    imupm_host_model host_u (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso_o));

    imupm_ctrl #(.BOOT_CYCLES(50)) dut_u (
        .mclk(mclk), .reset(reset), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso_o(miso_o), .spi_miso_oe(miso_oe), .core_addr(core_addr), .core_wr(core_wr),
        .core_wdata(core_wdata), .core_rdata(core_rdata), .accel_sample(accel_sample),
        .gyro_sample(gyro_sample), .accel_pwr(accel_pwr), .gyro_pwr(gyro_pwr), .accel_drdy(accel_drdy),
        .gyro_drdy(gyro_drdy), .trim_load(trim_load), .conn_mode(conn_mode),
        .hub_pullup_en(hub_pullup_en), .hub_sensor_count(hub_sensor_count));

    // ==========================================================
    // Shared tasks
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, a}, d, rd);
    endtask

    task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
        host_u.xfer({1'b1, a}, 8'h00, rd);
        `CHK(rd, e)
    endtask

    // A sample pulse must show within 40 cycles, two and a half tick periods at the fastest rate.
    task automatic wait_drdy(input bit g);
        for (int n = 0; n < 40 && !(g ? gyro_drdy : accel_drdy); n++) @(negedge mclk);
        `CHK(g ? gyro_drdy : accel_drdy, 1'b1)
    endtask

    task automatic print_verdict;
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_boot;
        int n;
        @(negedge mclk);
        `CHK(trim_load, 1'b1)
        for (n = 0; n < 60 && trim_load; n++) @(negedge mclk);
        `CHK(n <= 50, 1'b1)
        `CHK(accel_pwr.mode, PM_DOWN)
        `CHK(gyro_pwr.mode, PM_DOWN)
        `CHK(conn_mode, CM_PLAIN)
    endtask

    task automatic t_banks;
        wr(7'h01, 8'h80);
        @(posedge mclk);
        core_addr  <= 7'h05;
        core_wdata <= 8'hA5;
        core_wr    <= 1'b1;
        @(posedge mclk);
        core_wr    <= 1'b0;
        chk_rd(7'h05, 8'hA5);
        wr(7'h01, 8'h00);
        chk_rd(7'h05, MEM_RESET);
        `CHK(core_rdata, 8'hA5)
        chk_rd(7'h01, 8'h00);
    endtask

    task automatic t_hub;
        wr(7'h01, 8'h40);
        wr(7'h14, 8'h08);
        wr(7'h01, 8'h00);
        `CHK(hub_pullup_en, 1'b1)
        chk_rd(7'h14, MEM_RESET);
        wr(7'h01, 8'h40);
        chk_rd(7'h14, 8'h08);
        wr(7'h14, 8'h07);
        `CHK(conn_mode, CM_HUB)
        `CHK(hub_sensor_count, 3'h4)
        wr(7'h14, 8'h00);
        wr(7'h01, 8'h00);
    endtask

    task automatic t_modes;
        wr(7'h10, 8'hA0);
        `CHK(accel_pwr.mode, PM_HIGH)
        wait_drdy(1'b0);
        chk_rd(7'h28, 8'hC3);
        wr(7'h15, 8'h10);
        `CHK(accel_pwr.mode, PM_LOW)
        wait_drdy(1'b0);
        wr(7'h11, 8'h90);
        wr(7'h16, 8'h80);
        `CHK(gyro_pwr.mode, PM_LOW)
        `CHK(gyro_pwr.drive_on, 1'b1)
        wait_drdy(1'b1);
        chk_rd(7'h22, 8'h5A);
        wr(7'h13, 8'h40);
        `CHK(gyro_pwr.mode, PM_SLEEP)
        `CHK(gyro_pwr.drive_on, 1'b1)
        wr(7'h11, 8'h00);
        `CHK(gyro_pwr.mode, PM_DOWN)
        @(posedge mclk);
        gyro_sample <= 48'h1111_2222_3366;
        repeat (40) @(posedge mclk);
        chk_rd(7'h22, 8'h5A);
        chk_rd(7'h13, 8'h40);
        chk_rd(7'h15, 8'h10);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        reset        = 1'b1;
        core_addr    = 7'h00;
        core_wr      = 1'b0;
        core_wdata   = 8'h00;
        accel_sample = 48'h0102_0304_05C3;
        gyro_sample  = 48'h0A0B_0C0D_0E5A;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        t_boot();
        t_banks();
        t_hub();
        t_modes();
        print_verdict();
    end

    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule
